// *** src/irq_ctrl_consts.svh ***
/*
  Offsets, field positions, reset values and encodings of the interrupt controller.
  Assumes inclusion by bare name from the package and the controller module.
*/
// Function
// - Reset, NMI, hard fault fixed at -3, -2, -1
// - Smaller priority value wins; fixed beat configurable
// - Other exceptions take programmable priority 0 to 3
// - Only strictly more urgent exceptions pre-empt handlers
// - At most four handlers nested at once
// - Equal priority ties go to lowest number
// - Four 2-bit priority fields per word
// - Bits outside priority fields ignored in arbitration
// - Disabled lines are not processed
// - Set-enable and clear-enable writes; both read state
// - Zero bits written change nothing
// - Enable and pending act on lines 0-15 only
// - Global mask blocks all configurable exceptions
// - Masked exceptions stay pending, served after unmask
// - Status bits 8:0 show active exception number
// - Status bits 20:12 show top pending number
// - Status bit 22 set when any line pends
// - Request pends; handler start makes it active
// - Set-pending and clear-pending writes; both read state
// - Repeated pending sets give one handler run
// - Pending writes ignore enable; request lines and service need enable
// - Sixteen lines, exception numbers 16 to 31
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

`define IRQ_N 16
`define NEST_MAX 3'h4
`define ADDR_W 8

`define OFS_SET_EN 8'h00
`define OFS_CLR_EN 8'h04
`define OFS_SET_PEND 8'h08
`define OFS_CLR_PEND 8'h0C
`define OFS_PRIO0 8'h10
`define OFS_PRIO3 8'h1C
`define OFS_CTRL_STATE 8'h20
`define OFS_GMASK 8'h24

`define PRIO_FIELD_POS 6
`define PRIO_FIELD_STRIDE 8
`define CS_ACT_LSB 0
`define CS_PEND_LSB 12
`define CS_ISR_BIT 22
`define GMASK_BIT 0

`define RANK_RESET 3'h0
`define RANK_NMI 3'h1
`define RANK_HF 3'h2
`define RANK_CFG_BASE 3'h3
`define RANK_THREAD 3'h7

`define EXC_NONE 9'h000
`define EXC_NMI 9'h002
`define EXC_HF 9'h003
`define EXC_IRQ_BASE 9'h010

`define EN_RESET 16'h0000
`define PEND_RESET 16'h0000
`define PRIO_RESET 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** src/irq_ctrl_pkg.sv ***
/*
  Types of the interrupt controller: bus carriers, handshake states, state record.
  Assumes the constants header is on the include path.
*/
`include "irq_ctrl_consts.svh"

package irq_ctrl_pkg;

  typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} wr_state_e;
  typedef enum logic [0:0] {R_IDLE = 1'b0, R_DATA = 1'b1} rd_state_e;

  typedef struct packed {
    logic awvalid;
    logic [`ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic valid;
    logic [8:0] num;
    logic [2:0] rank;
  } cand_s;

  typedef struct packed {
    logic [`IRQ_N-1:0] en;
    logic [`IRQ_N-1:0] pend;
    logic [`IRQ_N-1:0] act;
    logic [`IRQ_N-1:0][1:0] prio;
    logic mask;
    logic nmi_pend;
    logic hf_pend;
    logic [3:0][8:0] stk_num;
    logic [3:0][2:0] stk_rank;
    logic [2:0] depth;
    logic req;
    logic [8:0] req_num;
    logic [2:0] req_rank;
    logic [8:0] top_num;
    logic [8:0] act_num;
    wr_state_e wst;
    rd_state_e rst;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctrl_state_s;

endpackage

// *** src/nested_irq_priority_pending_ctrl.sv ***
/*
  Nested priority interrupt controller: enables, pending, priorities, global mask,
  handler nesting stack and status word, behind an AXI4-Lite register slave.
  Assumes the core pulses I_EXC_TAKE when it starts the offered handler and
  I_EXC_RETURN when a handler ends; request lines come from same-clock logic.
*/
`timescale 1ns/1ns
`include "irq_ctrl_consts.svh"

module nested_irq_priority_pending_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_IRQ = 16
) (
  // Clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_CORE_CE,
  // Register bus
  input wire axil_req_s I_AXI,
  output axil_rsp_s O_AXI,
  // Request sources
  input wire logic [`IRQ_N-1:0] I_IRQ,
  input wire logic I_NMI_EVT,
  input wire logic I_HARDFAULT_EVT,
  // Core handshake
  output logic O_EXC_REQ,
  output logic [8:0] O_EXC_NUM,
  input wire logic I_EXC_TAKE,
  input wire logic I_EXC_RETURN,
  output logic [8:0] O_ACTIVE_NUM
);

  if (NUM_IRQ != `IRQ_N) begin : g_bad_num
    $error("NUM_IRQ must equal the fixed line count");
  end

  ctrl_state_s r;
  ctrl_state_s n;
  logic wr_fire;
  logic rd_fire;
  logic take;
  logic ret;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [2:0] cur_rank;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [1:0] top_index(input logic [2:0] d);
    return 2'(d - 3'h1);
  endfunction

  // Lower rank is more urgent; loop order makes ties go to the lower number
  function automatic cand_s arbitrate(input ctrl_state_s s);
    cand_s c;
    logic [2:0] rk;
    c = '0;
    rk = `RANK_THREAD;
    c.rank = `RANK_THREAD;
    c.num = `EXC_NONE;
    if (s.nmi_pend) begin
      c.valid = 1'b1;
      c.num = `EXC_NMI;
      c.rank = `RANK_NMI;
    end
    if (s.hf_pend && (!c.valid || `RANK_HF < c.rank)) begin
      c.valid = 1'b1;
      c.num = `EXC_HF;
      c.rank = `RANK_HF;
    end
    for (int i = 0; i < `IRQ_N; i++) begin
      rk = 3'(s.prio[i]) + `RANK_CFG_BASE;
      if (s.pend[i] && s.en[i] && (!c.valid || rk < c.rank)) begin
        c.valid = 1'b1;
        c.num = `EXC_IRQ_BASE + 9'(i);
        c.rank = rk;
      end
    end
    return c;
  endfunction

  function automatic logic [32:0] read_word(input ctrl_state_s s, input logic [`ADDR_W-1:0] a);
    logic [31:0] d;
    logic err;
    d = '0;
    err = 1'b0;
    if (a == `OFS_SET_EN || a == `OFS_CLR_EN) begin
      d[`IRQ_N-1:0] = s.en;
    end else if (a == `OFS_SET_PEND || a == `OFS_CLR_PEND) begin
      d[`IRQ_N-1:0] = s.pend;
    end else if (a >= `OFS_PRIO0 && a <= `OFS_PRIO3 && a[1:0] == 2'h0) begin
      for (int k = 0; k < 4; k++) begin
        d[`PRIO_FIELD_STRIDE*k+`PRIO_FIELD_POS +: 2] = s.prio[4*(a[3:2])+k];
      end
    end else if (a == `OFS_CTRL_STATE) begin
      d[`CS_ACT_LSB +: 9] = s.act_num;
      d[`CS_PEND_LSB +: 9] = s.top_num;
      d[`CS_ISR_BIT] = |s.pend;
    end else if (a == `OFS_GMASK) begin
      d[`GMASK_BIT] = s.mask;
    end else begin
      err = 1'b1;
    end
    return {err, d};
  endfunction

  assign wr_fire = (r.wst == W_IDLE) && I_AXI.awvalid && I_AXI.wvalid;
  assign rd_fire = (r.rst == R_IDLE) && I_AXI.arvalid;
  assign wmask = strb_mask(I_AXI.wstrb);
  assign wbits = I_AXI.wdata & wmask;
  assign take = I_EXC_TAKE && r.req && (r.depth < `NEST_MAX);
  assign ret = I_EXC_RETURN && (r.depth != 3'h0) && !take;
  assign cur_rank = (r.depth == 3'h0) ? `RANK_THREAD : r.stk_rank[top_index(r.depth)];

  always_comb begin
    logic [`IRQ_N-1:0] set_v;
    logic [`IRQ_N-1:0] clr_v;
    logic [32:0] rw;
    logic [3:0] idx;
    logic [8:0] num;
    logic [2:0] crk;
    cand_s c;
    n = r;
    set_v = '0;
    clr_v = '0;
    rw = '0;
    idx = '0;
    num = '0;
    crk = `RANK_THREAD;
    c = '0;

    // Register writes; address and data are taken together
    if (wr_fire) begin
      n.wst = W_RESP;
      n.bresp = `RESP_OKAY;
      if (I_AXI.awaddr == `OFS_SET_EN) begin
        n.en = r.en | wbits[`IRQ_N-1:0];
      end else if (I_AXI.awaddr == `OFS_CLR_EN) begin
        n.en = r.en & ~wbits[`IRQ_N-1:0];
      end else if (I_AXI.awaddr == `OFS_SET_PEND) begin
        set_v = wbits[`IRQ_N-1:0];
      end else if (I_AXI.awaddr == `OFS_CLR_PEND) begin
        clr_v = wbits[`IRQ_N-1:0];
      end else if (I_AXI.awaddr >= `OFS_PRIO0 && I_AXI.awaddr <= `OFS_PRIO3 &&
                   I_AXI.awaddr[1:0] == 2'h0) begin
        for (int k = 0; k < 4; k++) begin
          if (I_AXI.wstrb[k]) begin
            n.prio[4*(I_AXI.awaddr[3:2])+k] =
              I_AXI.wdata[`PRIO_FIELD_STRIDE*k+`PRIO_FIELD_POS +: 2];
          end
        end
      end else if (I_AXI.awaddr == `OFS_GMASK) begin
        if (I_AXI.wstrb[0]) begin
          n.mask = I_AXI.wdata[`GMASK_BIT];
        end
      end else if (I_AXI.awaddr == `OFS_CTRL_STATE) begin
        n.bresp = `RESP_OKAY;
      end else begin
        n.bresp = `RESP_SLVERR;
      end
    end else if (r.wst == W_RESP && I_AXI.bready) begin
      n.wst = W_IDLE;
    end

    if (rd_fire) begin
      rw = read_word(r, I_AXI.araddr);
      n.rst = R_DATA;
      n.rdata = rw[31:0];
      n.rresp = rw[32] ? `RESP_SLVERR : `RESP_OKAY;
    end else if (r.rst == R_DATA && I_AXI.rready) begin
      n.rst = R_IDLE;
    end

    // Enabled lines pend; a level still high during its handler re-pends it
    set_v = set_v | (I_IRQ & r.en);

    // Handler start: pending to active, pushed on the nesting stack
    if (take) begin
      n.stk_num[r.depth[1:0]] = r.req_num;
      n.stk_rank[r.depth[1:0]] = r.req_rank;
      n.depth = r.depth + 3'h1;
      if (r.req_num >= `EXC_IRQ_BASE) begin
        idx = r.req_num[3:0];
        n.act[idx] = 1'b1;
        clr_v[idx] = 1'b1;
      end else if (r.req_num == `EXC_NMI) begin
        n.nmi_pend = 1'b0;
      end else begin
        n.hf_pend = 1'b0;
      end
    end else if (ret) begin
      num = r.stk_num[top_index(r.depth)];
      n.depth = r.depth - 3'h1;
      if (num >= `EXC_IRQ_BASE) begin
        n.act[num[3:0]] = 1'b0;
      end
    end

    // Events win over a clear in the same cycle
    if (I_NMI_EVT) begin
      n.nmi_pend = 1'b1;
    end
    if (I_HARDFAULT_EVT) begin
      n.hf_pend = 1'b1;
    end
    n.pend = (r.pend & ~clr_v) | set_v;

    // Offer to the core; mask holds configurable ones pending only
    c = arbitrate(n);
    crk = (n.depth == 3'h0) ? `RANK_THREAD : n.stk_rank[top_index(n.depth)];
    n.req = c.valid && (c.rank < crk) && (n.depth < `NEST_MAX) &&
            !(n.mask && c.rank >= `RANK_CFG_BASE);
    n.req_num = c.num;
    n.req_rank = c.rank;
    n.top_num = c.valid ? c.num : `EXC_NONE;
    n.act_num = (n.depth == 3'h0) ? `EXC_NONE : n.stk_num[top_index(n.depth)];
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '0;
      r.en <= `EN_RESET;
      r.pend <= `PEND_RESET;
      r.prio <= `PRIO_RESET;
      r.wst <= W_IDLE;
      r.rst <= R_IDLE;
    end else if (I_CORE_CE) begin
      r <= n;
    end
  end

  // Ready terms are combinational, data from flops
  always_comb begin
    O_AXI = '0;
    O_AXI.awready = wr_fire;
    O_AXI.wready = wr_fire;
    O_AXI.bvalid = (r.wst == W_RESP);
    O_AXI.bresp = r.bresp;
    O_AXI.arready = (r.rst == R_IDLE);
    O_AXI.rvalid = (r.rst == R_DATA);
    O_AXI.rdata = r.rdata;
    O_AXI.rresp = r.rresp;
  end

  assign O_EXC_REQ = r.req;
  assign O_EXC_NUM = r.req_num;
  assign O_ACTIVE_NUM = r.act_num;

  a_mask_blocks_cfg: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.mask && O_EXC_REQ) |-> (O_EXC_NUM == `EXC_NMI || O_EXC_NUM == `EXC_HF))
    else $error("configurable exception offered while masked");

  a_strict_preempt: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    O_EXC_REQ |-> (r.req_rank < cur_rank))
    else $error("offered exception not strictly more urgent");

  a_nest_limit: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.depth == `NEST_MAX) |-> !O_EXC_REQ ##1 (r.depth <= `NEST_MAX))
    else $error("nesting beyond four handlers");

  a_take_activates: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (take && r.req_num >= `EXC_IRQ_BASE) |=>
      (r.act[$past(r.req_num[3:0])] && r.depth == $past(r.depth) + 3'h1 &&
       O_ACTIVE_NUM == $past(r.req_num)))
    else $error("taken line not made active");

  a_set_enable_write: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_SET_EN) |=> ((r.en & $past(wbits[15:0])) == $past(wbits[15:0])))
    else $error("set-enable bit did not enable");

  a_zero_write_idle: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_CLR_EN && wbits == 32'h00000000) |=> $stable(r.en))
    else $error("zero write changed enables");

  a_hw_set_wins: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (|(I_IRQ & r.en)) |=> ((r.pend & $past(I_IRQ & r.en)) == $past(I_IRQ & r.en)))
    else $error("enabled request failed to pend");

  a_status_read: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (rd_fire && I_AXI.araddr == `OFS_CTRL_STATE) |=>
      (O_AXI.rvalid && O_AXI.rdata[8:0] == $past(r.act_num) &&
       O_AXI.rdata[`CS_ISR_BIT] == $past(|r.pend)))
    else $error("status word does not match state");

  // Write side: each set or clear register acts only on its own one bits; priority fields take strobed bytes whole
  a_clear_enable_write: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_CLR_EN) |=>
      ((r.en & $past(wbits[15:0])) == 16'h0000))
    else $error("clear-enable bit did not disable");

  a_set_pend_write: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_SET_PEND) |=>
      ((r.pend & $past(wbits[15:0])) == $past(wbits[15:0])))
    else $error("set-pending bit did not pend");

  a_clear_pend_write: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_CLR_PEND) |=>
      ((r.pend & $past(wbits[15:0] & ~(I_IRQ & r.en))) == 16'h0000))
    else $error("clear-pending bit left line pending");

  a_zero_clear_pend: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_CLR_PEND && wbits[15:0] == 16'h0000 && !take) |=>
      ((r.pend & $past(r.pend)) == $past(r.pend)))
    else $error("zero clear-pending write dropped a line");

  a_prio_field_write: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (wr_fire && I_AXI.awaddr == `OFS_PRIO0 && I_AXI.wstrb[0]) |=>
      (r.prio[0] == $past(I_AXI.wdata[`PRIO_FIELD_POS +: 2])))
    else $error("first priority field not written");

  a_mask_keeps_pend: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.mask && !take && !(wr_fire && I_AXI.awaddr == `OFS_CLR_PEND)) |=>
      ((r.pend & $past(r.pend)) == $past(r.pend)))
    else $error("masked line lost its pending state");

  // Offer side: rules the core relies on without checking them itself
  a_nmi_outranks_all: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.nmi_pend && r.depth < `NEST_MAX && cur_rank > `RANK_NMI) |->
      (O_EXC_REQ && O_EXC_NUM == `EXC_NMI))
    else $error("pending non-maskable exception not offered first");

  a_hf_ignores_mask: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.hf_pend && !r.nmi_pend && r.depth < `NEST_MAX && cur_rank > `RANK_HF) |->
      (O_EXC_REQ && O_EXC_NUM == `EXC_HF))
    else $error("pending hard fault not offered");

  a_fixed_first: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (O_EXC_REQ && O_EXC_NUM >= `EXC_IRQ_BASE) |->
      (!r.nmi_pend && !r.hf_pend))
    else $error("line offered ahead of a fixed exception");

  a_offer_enabled: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (O_EXC_REQ && O_EXC_NUM >= `EXC_IRQ_BASE) |->
      r.en[O_EXC_NUM[3:0]])
    else $error("disabled line offered");

  a_offer_pending: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (O_EXC_REQ && O_EXC_NUM >= `EXC_IRQ_BASE) |->
      r.pend[O_EXC_NUM[3:0]])
    else $error("line offered without pending state");

  a_return_pops: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    ret |=>
      (r.depth == $past(r.depth) - 3'h1))
    else $error("handler return did not resume the one below");

  a_thread_zero: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N || !I_CORE_CE)
    (r.depth == 3'h0) |->
      (O_ACTIVE_NUM == `EXC_NONE))
    else $error("active number not zero in thread mode");

  // Low enable must freeze every flop, bus handshake included
  a_ce_freezes_state: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !I_CORE_CE |=>
      $stable(r))
    else $error("state moved while clock enable low");

endmodule

// *** test/core_model.sv ***
/*
  Core stand-in: takes each offered exception, returns a handler on command.
  Assumes one-cycle take and return pulses on the controller's clock.
*/
`timescale 1ns/1ns

module core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bench controls
  input wire logic i_take_en,
  input wire logic i_ret_cmd,
  // Controller side
  input wire logic i_exc_req,
  output logic o_take,
  output logic o_ret
);
  // Gap after each take lets the offer be recomputed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_take <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      o_take <= i_take_en & i_exc_req & ~o_take;
      o_ret <= i_ret_cmd;
    end
  end
endmodule

// *** test/tb_top.sv ***
/*
  Self-checking bench: register bus master, random arbitration, nesting, masking.
  Assumes the controller package and the core model are compiled first.
*/
`timescale 1ns/1ns

module tb_top
  import irq_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  axil_req_s axi = '0;
  axil_rsp_s rsp;
  logic [15:0] irq = '0;
  logic nmi = 1'b0;
  logic hf = 1'b0;
  logic take_en = 1'b0;
  logic ret_cmd = 1'b0;
  logic ce = 1'b1;
  logic exc_req;
  logic take;
  logic ret;
  logic [8:0] exc_num;
  logic [8:0] act_num;
  logic [31:0] rd;
  logic [31:0] seed = 32'h2462;
  logic [1:0] rr;
  int errors = 0;
  int check_count = 0;

  always #20 clk = ~clk;

  nested_irq_priority_pending_ctrl #(.NUM_IRQ(16)) u_nested_irq_priority_pending_ctrl (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CORE_CE(ce), .I_AXI(axi), .O_AXI(rsp),
    .I_IRQ(irq), .I_NMI_EVT(nmi), .I_HARDFAULT_EVT(hf), .O_EXC_REQ(exc_req),
    .O_EXC_NUM(exc_num), .I_EXC_TAKE(take), .I_EXC_RETURN(ret), .O_ACTIVE_NUM(act_num));

  core_model u_core_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_take_en(take_en), .i_ret_cmd(ret_cmd),
    .i_exc_req(exc_req), .o_take(take), .o_ret(ret));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Lowest priority value wins, strict compare keeps the lowest number on ties
  function automatic logic [8:0] best(input logic [15:0] p, input logic [15:0] e,
                                      input logic [3:0][31:0] pr);
    logic [8:0] n;
    logic [2:0] bp;
    n = 9'h000;
    bp = 3'h4;
    for (int i = 0; i < 16; i++) begin
      if (p[i] && e[i] && {1'b0, pr[i / 4][(i % 4) * 8 + 6 +: 2]} < bp) begin
        bp = {1'b0, pr[i / 4][(i % 4) * 8 + 6 +: 2]};
        n = 9'h010 + 9'(i);
      end
    end
    return n;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout(input int n);
    if (n >= 64) begin
      $display("FAIL wait expected done seen timeout");
      errors++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    @(posedge clk);
    axi.awaddr <= a;
    axi.wdata <= d;
    axi.wstrb <= s;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    for (n = 0; n < 64 && rsp.awready !== 1'b1; n++) @(posedge clk);
    timeout(n);
    axi.awvalid <= 1'b0;
    axi.wvalid <= 1'b0;
    for (n = 0; n < 64 && !(n > 0 && rsp.bvalid === 1'b1); n++) @(posedge clk);
    timeout(n);
    axi.bready <= 1'b0;
    chk("write response", 32'h0, {30'h0, rsp.bresp});
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    axi.araddr <= a;
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    for (n = 0; n < 64 && !(n > 0 && rsp.arready === 1'b1); n++) @(posedge clk);
    timeout(n);
    axi.arvalid <= 1'b0;
    for (n = 0; n < 64 && !(n > 0 && rsp.rvalid === 1'b1); n++) @(posedge clk);
    timeout(n);
    axi.rready <= 1'b0;
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask

  task automatic wait_act(input logic [8:0] e);
    int n;
    for (n = 0; n < 64 && act_num !== e; n++) @(posedge clk);
    timeout(n);
    chk("active number", 32'(e), 32'(act_num));
  endtask

  task automatic give_back();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
  endtask

  initial begin
    logic [3:0][31:0] pr;
    logic [31:0] en;
    logic [31:0] pd;
    logic [8:0] b;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rdr(8'(i * 4));
      chk("reset value", 32'h0, rd);
    end
    rdr(8'h40);
    chk("unmapped response", 32'h2, {30'h0, rr});
    seed = lfsr(seed);
    en = seed;
    wr(8'h00, en);
    seed = lfsr(seed);
    wr(8'h04, seed);
    en = en & ~seed & 32'h0000FFFF;
    rdr(8'h00);
    chk("enable set side", en, rd);
    rdr(8'h04);
    chk("enable clear side", en, rd);
    wr(8'h04, 32'h0);
    rdr(8'h00);
    chk("zero clear write", en, rd);
    for (int k = 0; k < 6; k++) begin
      wr(8'h0C, 32'hFFFFFFFF);
      for (int g = 0; g < 4; g++) begin
        seed = lfsr(seed);
        pr[g] = seed;
        wr(8'h10 + 8'(g * 4), seed);
        rdr(8'h10 + 8'(g * 4));
        chk("priority group", seed & 32'hC0C0C0C0, rd);
      end
      seed = lfsr(seed);
      en = seed;
      wr(8'h04, 32'hFFFFFFFF);
      wr(8'h00, en);
      seed = lfsr(seed);
      pd = seed;
      wr(8'h08, pd);
      wr(8'h0C, 32'hFFFF0000);
      rdr(8'h08);
      chk("pending", pd & 32'h0000FFFF, rd);
      b = best(pd[15:0], en[15:0], pr);
      rdr(8'h20);
      chk("top pending", 32'(b), 32'(rd[20:12]));
      chk("any pending", 32'(|pd[15:0]), 32'(rd[22]));
      chk("offer", (b != 0) ? {23'h1, b} : 32'h0,
          exc_req ? {23'h1, exc_num} : 32'h0);
    end
    wr(8'h0C, 32'hFFFF);
    wr(8'h00, 32'hFFFF);
    wr(8'h10, 32'h004080C0);
    wr(8'h14, 32'h0);
    wr(8'h14, 32'hFFFFFF00, 4'h1);
    rdr(8'h14);
    chk("strobed priority", 32'h0, rd);
    take_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 32'h1 << i);
      wait_act(9'h010 + 9'(i));
    end
    wr(8'h08, 32'h10);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    // Absence of a fifth offer needs a window of its own
    repeat (8) @(posedge clk);
    chk("nest limit", 32'h013, {22'h0, exc_req, act_num});
    rdr(8'h20);
    chk("active field", 32'h013, {23'h0, rd[8:0]});
    give_back();
    wait_act(9'h002);
    give_back();
    wait_act(9'h014);
    give_back();
    wait_act(9'h012);
    rst_n <= 1'b0;
    take_en <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h00, 32'hFFFF);
    wr(8'h24, 32'h1);
    take_en <= 1'b1;
    ce <= 1'b0;
    irq <= 16'h0001;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    irq <= 16'h00A0;
    repeat (4) @(posedge clk);
    irq <= 16'h0;
    rdr(8'h20);
    chk("masked status", 32'h00415000, rd & 32'h005FF1FF);
    hf <= 1'b1;
    @(posedge clk);
    hf <= 1'b0;
    wait_act(9'h003);
    wr(8'h08, 32'h20);
    wr(8'h08, 32'h20);
    give_back();
    wr(8'h24, 32'h0);
    wait_act(9'h015);
    rdr(8'h08);
    chk("pending after take", 32'h80, rd);
    give_back();
    wait_act(9'h017);
    wr(8'h08, 32'h80);
    rdr(8'h08);
    chk("active and pending", 32'h80, rd);
    report_and_stop();
  end
endmodule
